/* design/mvic_pkg.sv */
// constants of the multilevel vectored interrupt controller
package mvic_pkg;

  // ----------------------------------------
  // sizes
  // ----------------------------------------
  localparam int NUM_SRC = 22;
  localparam int NUM_VEC = 10;
  localparam int NUM_EXT = 6;
  localparam int NUM_PER = 16;
  localparam int VEC_W = 20;
  localparam int VIDX_W = 4;
  localparam int TRIG_W = 3;
  localparam int LVL_W = 2;
  localparam int ISR_W = 3;
  localparam int STBY_W = 2;

  // ----------------------------------------
  // priority levels, ranked by code
  // ----------------------------------------
  localparam logic [1:0] LVL_NONE = 2'h0;
  localparam logic [1:0] LVL_LOW = 2'h1;
  localparam logic [1:0] LVL_HIGH = 2'h2;
  localparam logic [1:0] LVL_TOP = 2'h3;
  localparam int ISR_B_LOW = 0;
  localparam int ISR_B_HIGH = 1;
  localparam int ISR_B_TOP = 2;

  // ----------------------------------------
  // external pin trigger modes
  // ----------------------------------------
  localparam logic [2:0] TRIG_RISE = 3'h0;
  localparam logic [2:0] TRIG_FALL = 3'h1;
  localparam logic [2:0] TRIG_BOTH = 3'h2;
  localparam logic [2:0] TRIG_HIGH = 3'h3;
  localparam logic [2:0] TRIG_LOW = 3'h4;
  // one bit per mode code, set where the pin supports it
  localparam logic [4:0] MODES_EDGE_LVL = 5'h1b;
  localparam logic [4:0] MODES_EDGE = 5'h07;
  localparam int NUM_LVL_PINS = 2;

  // ----------------------------------------
  // standby modes
  // ----------------------------------------
  localparam logic [1:0] STBY_RUN = 2'h0;
  localparam logic [1:0] STBY_HALT = 2'h1;
  localparam logic [1:0] STBY_HOLD = 2'h2;
  localparam logic [1:0] STBY_XHOLD = 2'h3;

  // ----------------------------------------
  // source layout: ext pins 0..5, then peripherals
  // ----------------------------------------
  localparam int SRC_EXT0 = 0;
  localparam int SRC_PORT0 = 17;
  localparam int SRC_BASE_TMR = 21;
  localparam logic [5:0] HOLD_PIN_MASK = 6'h37;
  localparam int VEC_EXT0 = 0;
  localparam int VEC_EXT1 = 1;
  localparam int VEC_SHARE_BT = 3;
  localparam int VEC_PORT0 = 9;

  localparam logic [21:0] VEC_SRC_MASK [0:NUM_VEC-1] = '{
    22'h000001, 22'h000002, 22'h000054, 22'h200028, 22'h000080,
    22'h000300, 22'h000c00, 22'h003000, 22'h01c000, 22'h1e0000};

  localparam logic [19:0] VEC_ADDR [0:NUM_VEC-1] = '{
    20'h00003, 20'h0000b, 20'h00013, 20'h0001b, 20'h00023,
    20'h0002b, 20'h00033, 20'h0003b, 20'h00043, 20'h0004b};

endpackage : mvic_pkg

/* design/mvic_ext_det.sv */
// trigger detector for one external interrupt pin
`timescale 1ns/1ps
module mvic_ext_det #(
  parameter logic [4:0] ALLOW_MODES = 5'h1f
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // pin and mode
  input wire logic pin_i,
  input wire logic [2:0] mode_i,
  // detection
  output logic hit_o,
  output logic lvl_o
);
  import mvic_pkg::*;

  logic prev_reg;
  logic mode_ok;

  // tracks the pin through reset too, so a pin already high gives no false edge
  always_ff @(posedge clk_i) begin
    prev_reg <= pin_i;
  end

  // unsupported modes never fire
  assign mode_ok = (mode_i <= TRIG_LOW) && ALLOW_MODES[mode_i]; // R15

  always_comb begin
    hit_o = 1'b0;
    lvl_o = 1'b0;
    if (mode_ok) begin
      case (mode_i)
        TRIG_RISE: begin
          hit_o = pin_i & ~prev_reg;
          lvl_o = pin_i;
        end
        TRIG_FALL: begin
          hit_o = ~pin_i & prev_reg;
          lvl_o = ~pin_i;
        end
        TRIG_BOTH: begin
          hit_o = pin_i ^ prev_reg;
          lvl_o = pin_i;
        end
        TRIG_HIGH: begin
          hit_o = pin_i;
          lvl_o = pin_i;
        end
        TRIG_LOW: begin
          hit_o = ~pin_i;
          lvl_o = ~pin_i;
        end
        default: begin
          hit_o = 1'b0;
          lvl_o = 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  chk_blocked_mode: // R15
  assert property (@(posedge clk_i) disable iff (rst_i)
    (mode_i > TRIG_LOW) || !ALLOW_MODES[mode_i] |-> !hit_o && !lvl_o)
    else $error("detector fired in an unsupported mode");

  chk_rise_edge: // R15
  assert property (@(posedge clk_i) disable iff (rst_i)
    (mode_i == TRIG_RISE) && ALLOW_MODES[TRIG_RISE] && pin_i && !$past(pin_i) |-> hit_o)
    else $error("rising edge missed");

endmodule : mvic_ext_det

/* design/mvic_ctrl.sv */
// multilevel vectored interrupt controller, 22 sources on 10 vectors
// Behaviour
// R1 - three levels rank highest above high above low in every arbitration.
// R2 - no request at or below the level in service is accepted.
// R3 - of several pending vectors the one with the highest level is granted first.
// R4 - among equal levels the smallest vector address wins.
// R5 - 22 sources merge onto 10 fixed vectors, shared ones told apart by software flags.
// R6 - ext_irq_zero goes to 00003h, ext_irq_one to 0000bh, each highest or low level.
// R7 - 00013h serves ext two, timer zero low half, ext four; 0001bh ext three, five, base timer.
// R8 - timer zero high half at 00023h, timer one halves at 0002bh, high or low level.
// R9 - serial zero and async receive at 00033h, serial one and async transmit at 0003bh.
// R10 - converter and timers six, seven at 00043h; port zero, timers four, five, pwm at 0004bh.
// R11 - in halt any pending interrupt wakes the core, peripherals keep running.
// R12 - in hold and crystal hold pins zero, one, two, four, five at their level wake the core.
// R13 - a port zero interrupt condition also ends hold.
// R14 - in crystal hold a base timer interrupt ends the mode.
// R15 - pins zero, one take edges and levels but not both edges; two, three take edges only.
// R16 - acceptance raises the service level and a return restores the previous one.
`timescale 1ns/1ps
module mvic_ctrl (
  // clock and reset
  input wire logic REF_CLK_I,
  input wire logic RST_I,
  // external interrupt pins
  input wire logic [mvic_pkg::NUM_EXT-1:0] EXT_PIN_I,
  input wire logic [mvic_pkg::NUM_EXT*mvic_pkg::TRIG_W-1:0] EXT_MODE_I,
  input wire logic [mvic_pkg::NUM_EXT-1:0] EXT_EN_I,
  input wire logic [mvic_pkg::NUM_EXT-1:0] EXT_FLAG_CLR_I,
  output logic [mvic_pkg::NUM_EXT-1:0] EXT_FLAG_O,
  // peripheral requests
  input wire logic [mvic_pkg::NUM_PER-1:0] PERIPH_REQ_I,
  // configuration
  input wire logic [mvic_pkg::NUM_VEC-1:0] VEC_LVL_SEL_I,
  input wire logic IRQ_GLOBAL_EN_I,
  // cpu handshake
  output logic IRQ_REQ_O,
  output logic [mvic_pkg::VEC_W-1:0] IRQ_VEC_O,
  output logic [mvic_pkg::LVL_W-1:0] IRQ_LVL_O,
  input wire logic IRQ_ACK_I,
  input wire logic IRQ_RETURN_I,
  output logic [mvic_pkg::ISR_W-1:0] ISR_LVL_O,
  // standby
  input wire logic [mvic_pkg::STBY_W-1:0] STBY_MODE_I,
  output logic WAKE_O
);
  import mvic_pkg::*;

  logic [NUM_EXT-1:0] ext_hit;
  logic [NUM_EXT-1:0] ext_lvl;
  logic [NUM_EXT-1:0] ext_flag_reg;
  logic [NUM_SRC-1:0] src;
  logic [NUM_VEC-1:0] vec_pend;
  logic [LVL_W-1:0] vec_lvl [NUM_VEC];
  logic [LVL_W-1:0] best_lvl;
  logic [VIDX_W-1:0] best_idx;
  logic [LVL_W-1:0] cur_lvl;
  logic grantable;
  logic ack_take;
  logic req_reg;
  logic [VEC_W-1:0] vec_addr_reg;
  logic [LVL_W-1:0] lvl_reg;
  logic [ISR_W-1:0] isr_reg;
  logic [ISR_W-1:0] isr_next;

  // ----------------------------------------
  // external pin detection
  // ----------------------------------------
  for (genvar e = 0; e < NUM_EXT; e++) begin : g_ext
    mvic_ext_det #(
      .ALLOW_MODES((e < NUM_LVL_PINS) ? MODES_EDGE_LVL : MODES_EDGE) // R15
    ) u_det (
      .clk_i(REF_CLK_I),
      .rst_i(RST_I),
      .pin_i(EXT_PIN_I[e]),
      .mode_i(EXT_MODE_I[e*TRIG_W +: TRIG_W]),
      .hit_o(ext_hit[e]),
      .lvl_o(ext_lvl[e])
    );
  end

  // sticky flags, a new hit beats the clear
  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      ext_flag_reg <= '0;
    end else begin
      ext_flag_reg <= (ext_flag_reg & ~EXT_FLAG_CLR_I) | (ext_hit & EXT_EN_I);
    end
  end

  assign EXT_FLAG_O = ext_flag_reg;
  assign src = {PERIPH_REQ_I, ext_flag_reg}; // R5

  // ----------------------------------------
  // per vector merge and level
  // ----------------------------------------
  for (genvar v = 0; v < NUM_VEC; v++) begin : g_vec
    assign vec_pend[v] = |(src & VEC_SRC_MASK[v]); // R5 R6 R7 R8 R9 R10
    always_comb begin
      if (!vec_pend[v]) begin
        vec_lvl[v] = LVL_NONE;
      end else if (v <= VEC_EXT1) begin
        vec_lvl[v] = VEC_LVL_SEL_I[v] ? LVL_TOP : LVL_LOW; // R6
      end else begin
        vec_lvl[v] = VEC_LVL_SEL_I[v] ? LVL_HIGH : LVL_LOW; // R7 R8 R9 R10
      end
    end
  end

  // ----------------------------------------
  // arbitration
  // ----------------------------------------
  // strict compare keeps the lowest index on ties
  always_comb begin
    best_lvl = LVL_NONE;
    best_idx = '0;
    for (int v = 0; v < NUM_VEC; v++) begin
      if (vec_lvl[v] > best_lvl) begin // R1 R3 R4
        best_lvl = vec_lvl[v];
        best_idx = VIDX_W'(v);
      end
    end
  end

  always_comb begin
    if (isr_reg[ISR_B_TOP]) begin
      cur_lvl = LVL_TOP;
    end else if (isr_reg[ISR_B_HIGH]) begin
      cur_lvl = LVL_HIGH;
    end else if (isr_reg[ISR_B_LOW]) begin
      cur_lvl = LVL_LOW;
    end else begin
      cur_lvl = LVL_NONE;
    end
  end

  assign grantable = IRQ_GLOBAL_EN_I && (best_lvl > cur_lvl); // R2
  assign ack_take = IRQ_ACK_I && req_reg;

  // offer drops for one cycle after acceptance so the new level applies
  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      req_reg <= 1'b0;
    end else begin
      req_reg <= grantable && !ack_take && !IRQ_RETURN_I; // R2
    end
  end

  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      vec_addr_reg <= '0;
      lvl_reg <= LVL_NONE;
    end else begin
      vec_addr_reg <= VEC_ADDR[best_idx]; // R3 R4
      lvl_reg <= best_lvl;
    end
  end

  assign IRQ_REQ_O = req_reg;
  assign IRQ_VEC_O = vec_addr_reg;
  assign IRQ_LVL_O = lvl_reg;

  // ----------------------------------------
  // in-service levels
  // ----------------------------------------
  // return is applied before a same-cycle acceptance
  always_comb begin
    isr_next = isr_reg;
    if (IRQ_RETURN_I) begin
      if (isr_reg[ISR_B_TOP]) begin
        isr_next[ISR_B_TOP] = 1'b0; // R16
      end else if (isr_reg[ISR_B_HIGH]) begin
        isr_next[ISR_B_HIGH] = 1'b0;
      end else begin
        isr_next[ISR_B_LOW] = 1'b0;
      end
    end
    if (ack_take) begin
      case (lvl_reg)
        LVL_TOP: isr_next[ISR_B_TOP] = 1'b1; // R16
        LVL_HIGH: isr_next[ISR_B_HIGH] = 1'b1;
        LVL_LOW: isr_next[ISR_B_LOW] = 1'b1;
        default: isr_next = isr_next;
      endcase
    end
  end

  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      isr_reg <= '0;
    end else begin
      isr_reg <= isr_next;
    end
  end

  assign ISR_LVL_O = isr_reg;

  // ----------------------------------------
  // standby wake-up
  // ----------------------------------------
  // combinational so it works with the clocks stopped
  always_comb begin
    case (STBY_MODE_I)
      STBY_HALT: WAKE_O = |vec_pend; // R11
      STBY_HOLD: WAKE_O = (|(ext_lvl & EXT_EN_I & HOLD_PIN_MASK)) || src[SRC_PORT0]; // R12 R13
      STBY_XHOLD: WAKE_O = (|(ext_lvl & EXT_EN_I & HOLD_PIN_MASK)) || src[SRC_PORT0]
                           || src[SRC_BASE_TMR]; // R12 R14
      default: WAKE_O = 1'b0;
    endcase
  end

  // ----------------------------------------
  // check helpers
  // ----------------------------------------
  logic [LVL_W-1:0] chk_max_lvl;
  logic [VIDX_W-1:0] chk_min_idx;
  logic [NUM_VEC-1:0] chk_is_top;
  logic [NUM_VEC-1:0] chk_is_high;

  for (genvar v = 0; v < NUM_VEC; v++) begin : g_chk
    assign chk_is_top[v] = (vec_lvl[v] == LVL_TOP);
    assign chk_is_high[v] = (vec_lvl[v] == LVL_HIGH);
  end

  always_comb begin
    if (|chk_is_top) begin
      chk_max_lvl = LVL_TOP;
    end else if (|chk_is_high) begin
      chk_max_lvl = LVL_HIGH;
    end else if (|vec_pend) begin
      chk_max_lvl = LVL_LOW;
    end else begin
      chk_max_lvl = LVL_NONE;
    end
  end

  always_comb begin
    chk_min_idx = '0;
    for (int v = NUM_VEC - 1; v >= 0; v--) begin
      if (vec_pend[v] && (vec_lvl[v] == chk_max_lvl)) begin
        chk_min_idx = VIDX_W'(v);
      end
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (RST_I);

  chk_offer_above_isr: // R2
  assert property (IRQ_REQ_O |-> IRQ_LVL_O > cur_lvl)
    else $error("offered level not above the level in service");

  chk_highest_level: // R1 R3
  assert property (grantable && !ack_take && !IRQ_RETURN_I |=> IRQ_REQ_O && IRQ_LVL_O == $past(chk_max_lvl))
    else $error("granted level is not the highest pending");

  chk_lowest_vector: // R4
  assert property (grantable && !ack_take && !IRQ_RETURN_I |=> IRQ_VEC_O == VEC_ADDR[$past(chk_min_idx)])
    else $error("tie not resolved to the smallest vector");

  chk_ext_zero_vec: // R6
  assert property (src == NUM_SRC'(1 << SRC_EXT0) && VEC_LVL_SEL_I[VEC_EXT0] && IRQ_GLOBAL_EN_I
                   && cur_lvl == LVL_NONE && !ack_take && !IRQ_RETURN_I
                   |=> IRQ_VEC_O == VEC_ADDR[VEC_EXT0] && IRQ_LVL_O == LVL_TOP)
    else $error("ext zero not at its vector with top level");

  chk_shared_vec: // R5 R7
  assert property (src == NUM_SRC'(1 << SRC_BASE_TMR) && IRQ_GLOBAL_EN_I && cur_lvl == LVL_NONE
                   && !ack_take && !IRQ_RETURN_I |=> IRQ_REQ_O && IRQ_VEC_O == VEC_ADDR[VEC_SHARE_BT])
    else $error("base timer not on its shared vector");

  chk_no_top_shared: // R7 R8 R9 R10
  assert property (IRQ_REQ_O && IRQ_VEC_O != VEC_ADDR[VEC_EXT0] && IRQ_VEC_O != VEC_ADDR[VEC_EXT1]
                   |-> IRQ_LVL_O != LVL_TOP)
    else $error("shared vector offered at top level");

  chk_ack_raises: // R16
  assert property (ack_take && !IRQ_RETURN_I |=> cur_lvl == $past(lvl_reg))
    else $error("service level not raised on acceptance");

  chk_return_restores: // R16
  assert property (IRQ_RETURN_I && !ack_take && isr_reg[ISR_B_TOP] && isr_reg[ISR_B_LOW]
                   && !isr_reg[ISR_B_HIGH] |=> cur_lvl == LVL_LOW ##1 cur_lvl == LVL_LOW || IRQ_ACK_I)
    else $error("previous level not restored on return");

  chk_halt_wake: // R11
  assert property (STBY_MODE_I == STBY_HALT && |vec_pend |-> WAKE_O)
    else $error("halt not ended by a pending interrupt");

  chk_hold_port0: // R13
  assert property (STBY_MODE_I == STBY_HOLD && src[SRC_PORT0] |-> WAKE_O)
    else $error("port zero did not end hold");

  chk_xhold_btimer: // R14
  assert property (STBY_MODE_I == STBY_XHOLD && src[SRC_BASE_TMR] |-> WAKE_O)
    else $error("base timer did not end crystal hold");

  chk_hold_pins: // R12
  assert property (STBY_MODE_I == STBY_HOLD && !src[SRC_PORT0] && !(|(ext_lvl & EXT_EN_I & HOLD_PIN_MASK))
                   |-> !WAKE_O)
    else $error("hold ended without a wake source");

  chk_flag_set_wins:
  assert property (ext_hit[SRC_EXT0] && EXT_EN_I[SRC_EXT0] && EXT_FLAG_CLR_I[SRC_EXT0]
                   |=> EXT_FLAG_O[SRC_EXT0])
    else $error("flag clear beat a new event");

  cov_top_grant: cover property (ack_take && lvl_reg == LVL_TOP);
  cov_nested: cover property (ack_take && cur_lvl == LVL_LOW ##[1:20] ack_take && lvl_reg == LVL_TOP);
  cov_return: cover property (IRQ_RETURN_I && isr_reg[ISR_B_HIGH]);
  cov_hold_wake: cover property (STBY_MODE_I == STBY_HOLD && WAKE_O);

endmodule : mvic_ctrl

/* verification/mvic_cpu_model.sv */
// cpu core model that accepts offered interrupt vectors
`timescale 1ns/1ps
module mvic_cpu_model (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // offer from controller
  input wire logic req_i,
  input wire logic [19:0] vec_i,
  input wire logic [1:0] lvl_i,
  // behaviour
  input wire logic auto_i,
  input wire logic [3:0] delay_i,
  // answers
  output logic ack_o,
  output logic [19:0] vec_o,
  output logic [1:0] lvl_o,
  output logic [7:0] n_ack_o
);
  logic [3:0] wait_reg;

  // ----------------------------------------
  // acceptance, prompt or after delay_i cycles
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      wait_reg <= 4'h0;
      vec_o <= 20'h00000;
      lvl_o <= 2'h0;
      n_ack_o <= 8'h00;
    end else begin
      ack_o <= 1'b0;
      if (ack_o && req_i) begin
        vec_o <= vec_i;
        lvl_o <= lvl_i;
        n_ack_o <= n_ack_o + 8'h01;
        wait_reg <= 4'h0;
      end else if (auto_i && req_i && !ack_o) begin
        if (wait_reg == delay_i) begin
          ack_o <= 1'b1;
          wait_reg <= 4'h0;
        end else begin
          wait_reg <= wait_reg + 4'h1;
        end
      end else begin
        wait_reg <= 4'h0;
      end
    end
  end
endmodule : mvic_cpu_model

/* verification/tb_mvic_ctrl.sv */
// self-checking testbench of the interrupt controller
`timescale 1ns/1ps
module tb_mvic_ctrl;
  import mvic_pkg::*;
  logic clk, rst, glob_en, ack, ret_pulse, irq_req, wake, auto_ack;
  logic [5:0] ext_pin, ext_en, flag_clr, ext_flag;
  logic [17:0] ext_mode;
  logic [15:0] periph;
  logic [9:0] lvl_sel;
  logic [19:0] irq_vec, cpu_vec;
  logic [1:0] irq_lvl, cpu_lvl, stby;
  logic [2:0] isr_lvl;
  logic [3:0] dly;
  logic [7:0] n_ack;
  int fails = 0;
  int n_tests = 0;
  // vector index of each source: pins 0..5, then peripherals
  int vidx [22] = '{0, 1, 2, 3, 2, 3, 2, 4, 5, 5, 6, 6, 7, 7, 8, 8, 8, 9, 9, 9, 9, 3};

  mvic_ctrl uut (.REF_CLK_I(clk), .RST_I(rst), .EXT_PIN_I(ext_pin), .EXT_MODE_I(ext_mode),
    .EXT_EN_I(ext_en), .EXT_FLAG_CLR_I(flag_clr), .EXT_FLAG_O(ext_flag), .PERIPH_REQ_I(periph),
    .VEC_LVL_SEL_I(lvl_sel), .IRQ_GLOBAL_EN_I(glob_en), .IRQ_REQ_O(irq_req), .IRQ_VEC_O(irq_vec),
    .IRQ_LVL_O(irq_lvl), .IRQ_ACK_I(ack), .IRQ_RETURN_I(ret_pulse), .ISR_LVL_O(isr_lvl),
    .STBY_MODE_I(stby), .WAKE_O(wake));

  mvic_cpu_model cpu (.clk_i(clk), .rst_i(rst), .req_i(irq_req), .vec_i(irq_vec), .lvl_i(irq_lvl),
    .auto_i(auto_ack), .delay_i(dly), .ack_o(ack), .vec_o(cpu_vec), .lvl_o(cpu_lvl), .n_ack_o(n_ack));

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick

  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task close_out;
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : close_out

  task take;
    logic [7:0] old;
    int k;
    old = n_ack;
    k = 0;
    auto_ack = 1'b1;
    while (n_ack === old && k < 40) begin
      tick(1);
      k++;
    end
    auto_ack = 1'b0;
    tick(1);
    chk(n_ack, old + 8'h01);
  endtask : take

  task ret;
    ret_pulse = 1'b1;
    tick(1);
    ret_pulse = 1'b0;
    tick(1);
  endtask : ret

  task quiet;
    ext_pin = '0;
    periph = '0;
    flag_clr = 6'h3f;
    tick(2);
    flag_clr = '0;
  endtask : quiet

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task sc_map;
    int v;
    logic [1:0] el;
    for (int p = 0; p < 2; p++) begin
      lvl_sel = p ? 10'h3ff : 10'h000;
      dly = p ? 4'h3 : 4'h0;
      for (int s = 0; s < 22; s++) begin
        v = vidx[s];
        el = (p == 0) ? LVL_LOW : ((v < 2) ? LVL_TOP : LVL_HIGH);
        if (s < 6) ext_pin[s] = 1'b1;
        else periph[s-6] = 1'b1;
        take();
        chk(cpu_vec, 32'h3 + 8 * v);
        chk(cpu_lvl, el);
        chk(isr_lvl, 3'h1 << (el - 2'h1));
        tick(3);
        chk(irq_req, 1'b0);
        quiet();
        ret();
        chk(isr_lvl, 3'h0);
      end
    end
  endtask : sc_map

  task sc_prio;
    lvl_sel = '0;
    periph = 16'hffff;
    tick(3);
    chk(irq_vec, 32'h13);
    chk(irq_lvl, LVL_LOW);
    lvl_sel[9] = 1'b1;
    tick(3);
    chk(irq_vec, 32'h4b);
    lvl_sel[1:0] = 2'h3;
    ext_pin[1:0] = 2'h3;
    tick(4);
    chk(irq_vec, 32'h3);
    chk(irq_lvl, LVL_TOP);
    lvl_sel[0] = 1'b0;
    tick(3);
    chk(irq_vec, 32'hb);
    quiet();
    lvl_sel = '0;
    tick(3);
    chk(irq_req, 1'b0);
  endtask : sc_prio

  task sc_nest;
    periph[0] = 1'b1;
    take();
    chk(isr_lvl, 3'h1);
    periph[1] = 1'b1;
    tick(4);
    chk(irq_req, 1'b0);
    lvl_sel[4] = 1'b1;
    tick(3);
    chk(irq_vec, 32'h23);
    take();
    chk(isr_lvl, 3'h3);
    lvl_sel[0] = 1'b1;
    ext_pin[0] = 1'b1;
    take();
    chk(cpu_lvl, LVL_TOP);
    chk(isr_lvl, 3'h7);
    quiet();
    ret();
    chk(isr_lvl, 3'h3);
    ret();
    chk(isr_lvl, 3'h1);
    ret();
    chk(isr_lvl, 3'h0);
    periph[0] = 1'b1;
    take();
    ext_pin[0] = 1'b1;
    take();
    chk(isr_lvl, 3'h5);
    quiet();
    ret();
    chk(isr_lvl, 3'h1);
    ret();
    chk(isr_lvl, 3'h0);
    lvl_sel = '0;
  endtask : sc_nest

  task trig(input int e, input logic [2:0] m, input logic st, input logic en, input logic ex);
    ext_en[e] = en;
    ext_pin[e] = st;
    ext_mode[3*e +: 3] = m;
    flag_clr[e] = 1'b1;
    tick(3);
    flag_clr[e] = 1'b0;
    ext_pin[e] = ~st;
    tick(3);
    chk(ext_flag[e], ex);
    // a clear against a standing level hit loses
    flag_clr[e] = 1'b1;
    tick(1);
    chk(ext_flag[e], ex && (m == TRIG_HIGH || m == TRIG_LOW));
    ext_pin[e] = 1'b0;
    ext_mode[3*e +: 3] = TRIG_RISE;
    ext_en[e] = 1'b1;
    flag_clr[e] = 1'b1;
    tick(3);
    flag_clr[e] = 1'b0;
    tick(1);
  endtask : trig

  task wk(input logic [1:0] md, input int src, input logic ex);
    stby = md;
    if (src >= 6) periph[src-6] = 1'b1;
    else if (src >= 0) ext_pin[src] = 1'b1;
    tick(2);
    chk(wake, ex);
    quiet();
    stby = STBY_RUN;
    tick(1);
  endtask : wk

  // ----------------------------------------
  // main sequence and watchdog
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  initial begin
    repeat (6000) @(posedge clk);
    fails++;
    close_out();
  end

  initial begin
    rst = 1'b1;
    glob_en = 1'b1;
    ext_pin = '0;
    ext_en = 6'h3f;
    ext_mode = '0;
    flag_clr = '0;
    periph = '0;
    lvl_sel = '0;
    ret_pulse = 1'b0;
    stby = STBY_RUN;
    auto_ack = 1'b0;
    dly = 4'h0;
    tick(2);
    rst = 1'b0;
    tick(1);
    chk(irq_req, 1'b0);
    chk(isr_lvl, 3'h0);
    sc_map();
    sc_prio();
    sc_nest();
    trig(0, TRIG_BOTH, 1'b0, 1'b1, 1'b0);
    trig(0, TRIG_FALL, 1'b1, 1'b1, 1'b1);
    trig(0, TRIG_LOW, 1'b1, 1'b1, 1'b1);
    trig(1, TRIG_HIGH, 1'b0, 1'b1, 1'b1);
    trig(2, TRIG_HIGH, 1'b0, 1'b1, 1'b0);
    trig(2, TRIG_BOTH, 1'b1, 1'b1, 1'b1);
    trig(3, TRIG_LOW, 1'b1, 1'b1, 1'b0);
    trig(4, TRIG_FALL, 1'b1, 1'b1, 1'b1);
    trig(5, TRIG_RISE, 1'b0, 1'b0, 1'b0);
    wk(STBY_HALT, 9, 1'b1);
    wk(STBY_HALT, -1, 1'b0);
    wk(STBY_HOLD, 3, 1'b0);
    wk(STBY_HOLD, 4, 1'b1);
    wk(STBY_XHOLD, 0, 1'b1);
    wk(STBY_HOLD, 17, 1'b1);
    wk(STBY_HOLD, 14, 1'b0);
    wk(STBY_HOLD, 21, 1'b0);
    wk(STBY_XHOLD, 21, 1'b1);
    wk(STBY_RUN, 21, 1'b0);
    close_out();
  end
endmodule : tb_mvic_ctrl
